/* core/sld_pkg.sv */
// shared constants and types for the segment panel driver
package sld_pkg;

  // ==========================================================
  // geometry
  localparam int SLD_SEGMENTS = 40;
  localparam int SLD_COMMONS = 4;
  localparam int SLD_PTR_W = 6;
  localparam logic [5:0] SLD_LAST_ENTRY = 6'h27;

  // ==========================================================
  // pointer field positions: high nibble write lands in bits 5:4
  localparam int SLD_PTR_LOW_LSB = 0;
  localparam int SLD_PTR_HIGH_LSB = 4;

  // ==========================================================
  // reset values
  localparam logic [5:0] SLD_PTR_RESET = 6'h00;
  localparam logic [3:0] SLD_ENTRY_RESET = 4'h0;

  // ==========================================================
  // watch clock division ratios for the alternating frequency
  localparam logic [8:0] SLD_DIV_64 = 9'h03F;
  localparam logic [8:0] SLD_DIV_128 = 9'h07F;
  localparam logic [8:0] SLD_DIV_256 = 9'h0FF;
  localparam logic [8:0] SLD_DIV_512 = 9'h1FF;
  localparam logic [1:0] SLD_RATIO_64 = 2'h0;
  localparam logic [1:0] SLD_RATIO_128 = 2'h1;
  localparam logic [1:0] SLD_RATIO_256 = 2'h2;
  localparam logic [1:0] SLD_RATIO_512 = 2'h3;

  // ==========================================================
  // drive level codes for one third bias (v0 lowest, v3 highest)
  localparam logic [1:0] SLD_LVL_V0 = 2'h0;
  localparam logic [1:0] SLD_LVL_V1 = 2'h1;
  localparam logic [1:0] SLD_LVL_V2 = 2'h2;
  localparam logic [1:0] SLD_LVL_V3 = 2'h3;

  // ==========================================================
  // common scan phase, one hot
  typedef enum logic [3:0] {
    SLD_PH_COM0 = 4'b0001,
    SLD_PH_COM1 = 4'b0010,
    SLD_PH_COM2 = 4'b0100,
    SLD_PH_COM3 = 4'b1000
  } sld_phase_t;

  // ==========================================================
  // one processor command, each strobe a single cycle
  typedef struct packed {
    logic pointer_low_nibble;      // load pointer bits 3:0
    logic pointer_high_nibble;     // load pointer bits 5:4
    logic store;                   // write nibble to pointed entry
    logic fetch;                   // read pointed entry
    logic display_on_instruction;  // start panel driving
    logic display_off_instruction; // stop panel driving
    logic [3:0] nibble;            // data from data memory
  } sld_cmd_t;

endpackage : sld_pkg

/* core/sld_driver.sv */
// segment panel driver: pattern memory, pointer, scan and bias levels
`timescale 1ns/100ps

// How it works
// - drive forty segments and four commons, quarter duty, third bias levels
// - alternating frequency is watch clock divided by 64, 128, 256 or 512
// - a full frame spans four alternating periods, so frame is a quarter of it
// - forty 4-bit pattern entries, one per segment, one bit per common
// - a one bit lights its dot, a zero bit leaves it dark
// - memory is scanned to the pins continuously with no program help
// - entry k drives segment k, bit n gives the dot during common n
// - on command starts driving, also in hold; off command stops it
// - during reset all dots dark, afterwards off until the on command
// - 6-bit pointer loaded by separate low and high nibble writes
// - memory reached only through the pointer by store and fetch
module sld_driver
  import sld_pkg::*;
#(
  parameter int SEGMENTS = SLD_SEGMENTS,
  parameter int COMMONS = SLD_COMMONS
)
(
  input wire logic sys_clk,                         // system clock, 40 mhz
  input wire logic rst,                             // async reset, active high
  input wire logic watch_crystal_clock,             // 32.768 khz watch clock level
  input wire logic [1:0] ratio_sel,                 // 0:/64 1:/128 2:/256 3:/512
  input wire sld_cmd_t cmd,                         // processor command strobes
  output logic [3:0] fetch_data,                    // nibble returned by fetch
  output logic fetch_valid,                         // one cycle after fetch
  output logic display_enabled,                     // panel driving active
  output logic [SEGMENTS-1:0][1:0] segment_outputs, // segment drive levels
  output logic [COMMONS-1:0][1:0] common_outputs,   // common drive levels
  output logic panel_alternating_frequency          // alternating clock, 50% duty
);

  // ==========================================================
  // elaboration checks: scan, pointer and phase logic are sized for these values only
  generate
    if (SEGMENTS != SLD_SEGMENTS)
    begin : g_bad_segments
      $error("sld_driver serves exactly 40 segments");
    end
    if (COMMONS != SLD_COMMONS)
    begin : g_bad_commons
      $error("sld_driver serves exactly 4 commons");
    end
    if (SEGMENTS > (1 << SLD_PTR_W))
    begin : g_bad_pointer
      $error("pointer too narrow to reach every entry");
    end
    if (int'(SLD_LAST_ENTRY) != SEGMENTS - 1)
    begin : g_bad_last
      $error("last entry index does not match the segment count");
    end
    if (SLD_PTR_HIGH_LSB + 2 != SLD_PTR_W)
    begin : g_bad_fields
      $error("pointer nibble fields do not fill the pointer");
    end
  endgenerate

  // ==========================================================
  // state
  logic [3:0] glass_pattern_memory [SEGMENTS];
  logic [SLD_PTR_W-1:0] display_ram_pointer;
  logic watch_prev;
  logic [8:0] div_cnt;
  sld_phase_t phase;
  logic polarity;
  logic [8:0] div_limit;
  logic watch_tick;
  logic div_end;
  logic ptr_valid;
  logic [1:0] com_index;
  logic frame_end;
  logic [SEGMENTS-1:0] seg_dot;
  logic [SEGMENTS-1:0][1:0] next_segment;
  logic [COMMONS-1:0][1:0] next_common;
  sld_phase_t next_phase;
  logic alt_level;
  logic load_low;
  logic load_high;
  logic [1:0] high_bits;
  logic store_hit;
  logic fetch_hit;
  logic turn_on;
  logic turn_off;
  logic [3:0] next_fetch_data;
  logic [SEGMENTS-1:0] entry_we;
  logic [1:0] seg_lit_level;
  logic [1:0] seg_dark_level;
  logic [1:0] com_select_level;
  logic [1:0] com_idle_level;
  genvar g;

  // ==========================================================
  // alternating frequency divider on watch clock rising edges
  assign watch_tick = watch_crystal_clock & ~watch_prev;
  assign div_limit = (ratio_sel == SLD_RATIO_64) ? SLD_DIV_64 :
                     (ratio_sel == SLD_RATIO_128) ? SLD_DIV_128 :
                     (ratio_sel == SLD_RATIO_256) ? SLD_DIV_256 :
                     SLD_DIV_512;
  assign div_end = watch_tick && (div_cnt >= div_limit);
  // alternating clock is high over the latter half of each period
  assign alt_level = (div_cnt > (div_limit >> 1));

  // divider counter; a lowered ratio folds the count back at the next watch clock rise
  // watch clock must stay below half of sys_clk, or rising edges are lost
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      watch_prev <= 1'b0;
      div_cnt <= 9'h000;
      panel_alternating_frequency <= 1'b0;
    end
    else
    begin
      watch_prev <= watch_crystal_clock;
      if (div_end)
      begin
        div_cnt <= 9'h000;
      end
      else if (watch_tick)
      begin
        div_cnt <= div_cnt + 9'h001;
      end
      panel_alternating_frequency <= alt_level;
    end
  end

  // ==========================================================
  // common scan: one common per alternating period, four per frame
  // scan runs on while the display is off, so an on command may start mid frame
  always_comb
  begin
    case (phase)
      SLD_PH_COM0: next_phase = SLD_PH_COM1;
      SLD_PH_COM1: next_phase = SLD_PH_COM2;
      SLD_PH_COM2: next_phase = SLD_PH_COM3;
      SLD_PH_COM3: next_phase = SLD_PH_COM0;
      default: next_phase = SLD_PH_COM0;
    endcase
  end

  assign frame_end = div_end && (phase == SLD_PH_COM3);

  // phase advance and per frame polarity flip
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= SLD_PH_COM0;
      polarity <= 1'b0;
    end
    else
    begin
      if (div_end)
      begin
        phase <= next_phase;
      end
      if (frame_end)
      begin
        polarity <= ~polarity;
      end
    end
  end

  // ==========================================================
  // pointer, display switch and pattern memory access
  assign ptr_valid = (display_ram_pointer <= SLD_LAST_ENTRY);

  // command decode; stores and fetches use the pointer held before this edge's load
  assign load_low = cmd.pointer_low_nibble;
  assign load_high = cmd.pointer_high_nibble;
  assign store_hit = cmd.store && ptr_valid;
  assign fetch_hit = cmd.fetch;
  assign turn_on = cmd.display_on_instruction;
  assign turn_off = cmd.display_off_instruction && !turn_on;
  // high nibble load keeps only two bits, the pointer is six wide
  assign high_bits = cmd.nibble[1:0];
  // a pointer past the last entry reads as zero, never as an undefined entry
  assign next_fetch_data = ptr_valid ? glass_pattern_memory[display_ram_pointer] : 4'h0;

  // write selects, one per entry; no select matches a pointer past the last entry
  generate
    for (g = 0; g < SEGMENTS; g++)
    begin : g_wsel
      assign entry_we[g] = store_hit && (display_ram_pointer == SLD_PTR_W'(g));
    end
  endgenerate

  // pointer loads and display on/off commands
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      display_ram_pointer <= SLD_PTR_RESET;
      display_enabled <= 1'b0;
    end
    else
    begin
      if (load_low)
      begin
        display_ram_pointer[SLD_PTR_LOW_LSB +: 4] <= cmd.nibble;
      end
      if (load_high)
      begin
        display_ram_pointer[SLD_PTR_HIGH_LSB +: 2] <= high_bits;
      end
      if (turn_on)
      begin
        display_enabled <= 1'b1;
      end
      else if (turn_off)
      begin
        display_enabled <= 1'b0;
      end
    end
  end

  // memory clears on reset so the first on command shows a dark glass
  // pattern memory store through the pointer only
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SEGMENTS; i++)
      begin
        glass_pattern_memory[i] <= SLD_ENTRY_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < SEGMENTS; i++)
      begin
        if (entry_we[i])
        begin
          glass_pattern_memory[i] <= cmd.nibble;
        end
      end
    end
  end

  // fetch answer, registered one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fetch_data <= 4'h0;
      fetch_valid <= 1'b0;
    end
    else
    begin
      fetch_valid <= fetch_hit;
      if (fetch_hit)
      begin
        fetch_data <= next_fetch_data;
      end
    end
  end

  // ==========================================================
  // bias levels: selected common at the far rail, dots swing across
  assign com_index = {phase[3] | phase[2], phase[3] | phase[1]};

  // the four levels of this frame; polarity swaps them so no dot sees a net dc voltage
  assign seg_lit_level = polarity ? SLD_LVL_V3 : SLD_LVL_V0;
  assign seg_dark_level = polarity ? SLD_LVL_V1 : SLD_LVL_V2;
  assign com_select_level = polarity ? SLD_LVL_V0 : SLD_LVL_V3;
  assign com_idle_level = polarity ? SLD_LVL_V2 : SLD_LVL_V1;

  generate
    for (g = 0; g < SEGMENTS; g++)
    begin : g_seg
      // entry g feeds segment g, bit picked by the active common
      assign seg_dot[g] = glass_pattern_memory[g][com_index];
      assign next_segment[g] = !display_enabled ? SLD_LVL_V0 :
                               (seg_dot[g] ? seg_lit_level : seg_dark_level);
    end
    for (g = 0; g < COMMONS; g++)
    begin : g_com
      assign next_common[g] = !display_enabled ? SLD_LVL_V0 :
                              (phase[g] ? com_select_level : com_idle_level);
    end
  endgenerate

  // pin levels registered; reset and off both hold every pin at v0
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      segment_outputs <= '0;
      common_outputs <= '0;
    end
    else
    begin
      segment_outputs <= next_segment;
      common_outputs <= next_common;
    end
  end

endmodule : sld_driver

/* bench/sld_properties.sv */
// checker for the segment panel driver ports
`timescale 1ns/100ps
module sld_props
  import sld_pkg::*;
#(
  parameter int SEGMENTS = SLD_SEGMENTS,
  parameter int COMMONS = SLD_COMMONS
)
(
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire sld_cmd_t cmd, // strobes
  input wire logic [3:0] fetch_data, // fetched nibble
  input wire logic fetch_valid, // fetch answer
  input wire logic display_enabled, // driving on
  input wire logic [SEGMENTS-1:0][1:0] segment_outputs, // segment levels
  input wire logic [COMMONS-1:0][1:0] common_outputs // common levels
);
  logic en_q;
  logic [2:0] act;
  logic hi;
  logic ok;
  // pins carry levels one cycle after the enable
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      en_q <= 1'b0;
    else
      en_q <= display_enabled;
  // count rail commons, check the others and all segments sit on the right bias side
  always_comb
  begin
    act = '0;
    hi = 1'b0;
    ok = 1'b1;
    for (int n = 0; n < COMMONS; n++)
    begin
      act = act + 3'(common_outputs[n][1] == common_outputs[n][0]);
      hi = hi | (common_outputs[n] == 2'h3);
    end
    for (int n = 0; n < COMMONS; n++)
      ok = ok & ((common_outputs[n][1] == common_outputs[n][0]) | (common_outputs[n] == {!hi, hi}));
    for (int k = 0; k < SEGMENTS; k++)
      ok = ok & (segment_outputs[k][0] == !hi);
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_fetch_answer: assert property (fetch_valid == $past(cmd.fetch))
    else $error("fetch answer timing wrong");
  a_fetch_hold: assert property (!$past(cmd.fetch) |-> $stable(fetch_data))
    else $error("fetch data moved without fetch");
  a_on_starts: assert property (cmd.display_on_instruction |=> display_enabled)
    else $error("display did not start");
  a_off_stops: assert property (cmd.display_off_instruction && !cmd.display_on_instruction |=> !display_enabled)
    else $error("display did not stop");
  a_off_dark: assert property (!en_q |-> segment_outputs == '0 && common_outputs == '0)
    else $error("pins driven while off");
  a_one_common: assert property (en_q |-> act == 3'd1)
    else $error("not exactly one common selected");
  a_bias_levels: assert property (en_q |-> ok)
    else $error("drive levels off bias");
  a_phase_hold: assert property (en_q && $past(en_q) && $changed(common_outputs)
    |=> ($stable(common_outputs) || !en_q)[*8])
    else $error("common phase too short");
  c_fetch: cover property (cmd.fetch);
  c_phase: cover property (en_q && $changed(common_outputs));
  c_off: cover property (cmd.display_off_instruction && display_enabled);
endmodule : sld_props

/* bench/sld_glass.sv */
// glass panel model: latches which dots see a full select voltage
`timescale 1ns/100ps
module sld_glass
  import sld_pkg::*;
(
  input wire logic sys_clk, // sampling clock
  input wire logic [39:0][1:0] segment_outputs, // segment levels
  input wire logic [3:0][1:0] common_outputs, // common levels
  output logic [39:0][3:0] dot_lit, // last seen dot state
  output logic [1:0] active_com, // selected common
  output logic mirror // selected common at the low rail
);
  // a dot lights only when segment and selected common sit on opposite rails
  always_ff @(posedge sys_clk)
    for (int n = 0; n < 4; n++)
      if (common_outputs[n] == 2'h0 || common_outputs[n] == 2'h3)
      begin
        active_com <= 2'(n);
        mirror <= common_outputs[n] == 2'h0;
        for (int k = 0; k < 40; k++)
          dot_lit[k][n] <= (segment_outputs[k] ^ common_outputs[n]) == 2'h3;
      end
endmodule : sld_glass

/* bench/test_segment_lcd_driver.sv */
// testbench for the segment panel driver
`timescale 1ns/100ps
module test_segment_lcd_driver
  import sld_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic watch = 1'b0;
  logic [1:0] ratio_sel = 2'h0;
  sld_cmd_t cmd = '0;
  logic [3:0] fetch_data;
  logic fetch_valid, display_enabled, paf, mirror;
  logic [39:0][1:0] segs;
  logic [3:0][1:0] coms;
  logic [39:0][3:0] dots;
  logic [1:0] com_idx;
  logic [3:0] pat [40];
  int error_cnt = 0;
  int check_count = 0;
  sld_driver dut (.sys_clk(sys_clk), .rst(rst), .watch_crystal_clock(watch), .ratio_sel(ratio_sel), .cmd(cmd),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid), .display_enabled(display_enabled),
    .segment_outputs(segs), .common_outputs(coms), .panel_alternating_frequency(paf));
  sld_glass panel (.sys_clk(sys_clk), .segment_outputs(segs), .common_outputs(coms), .dot_lit(dots),
    .active_com(com_idx), .mirror(mirror));
  // 40 mhz clock and a watch clock of four system cycles
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    forever
    begin
      repeat (2) @(posedge sys_clk);
      #2 watch = ~watch;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one command cycle; kind 6 is an idle cycle
  task automatic op(input int kind, input logic [3:0] v);
    cmd = sld_cmd_t'({6'(6'h20 >> kind), v});
    @(posedge sys_clk);
    #2;
  endtask : op
  task automatic wr(input logic [5:0] ptr, input logic [3:0] v);
    op(0, ptr[3:0]);
    op(1, {2'h0, ptr[5:4]});
    op(2, v);
  endtask : wr
  task automatic rd(input logic [5:0] ptr, input logic [3:0] exp);
    op(0, ptr[3:0]);
    op(1, {2'h0, ptr[5:4]});
    op(3, 4'h0);
    chk("fetch_valid", 16'h1, 16'(fetch_valid));
    chk("fetch_data", 16'(exp), 16'(fetch_data));
    op(6, 4'h0);
  endtask : rd
  // cycles between the second and third rise of the alternating clock or of common 0
  task automatic span(input logic frm, output int cyc);
    logic cur, prev;
    int rises;
    rises = 0;
    cyc = 0;
    prev = 1'b1;
    for (int i = 0; i < 40000 && rises < 3; i++)
    begin
      @(posedge sys_clk);
      #2 cur = frm ? com_idx == 2'h0 : paf;
      rises += int'(cur && !prev);
      cyc += int'(rises == 2);
      prev = cur;
    end
  endtask : span
  task automatic t_reset;
    rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("pins in reset", 16'h0, 16'(|{segs, coms}));
    #2 rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2;
    chk("display_enabled", 16'h0, 16'(display_enabled));
    chk("pins after reset", 16'h0, 16'(|{segs, coms}));
    $display("t_reset done");
  endtask : t_reset
  task automatic t_mem;
    wr(6'h15, 4'hA);
    rd(6'h15, 4'hA);
    op(0, 4'h7);
    op(1, 4'hE);
    op(2, 4'h5);
    rd(6'h27, 4'h5);
    wr(6'h28, 4'hF);
    rd(6'h28, 4'h0);
    rd(6'h00, 4'h0);
    for (int k = 0; k < 40; k++)
    begin
      pat[k] = 4'(k * 7 + 3);
      wr(6'(k), pat[k]);
    end
    op(6, 4'h0);
    $display("t_mem done");
  endtask : t_mem
  task automatic t_scan;
    logic [2:0] prev;
    int n;
    op(4, 4'h0);
    chk("display on", 16'h1, 16'(display_enabled));
    op(6, 4'h0);
    repeat (2100) @(posedge sys_clk);
    #2;
    for (int k = 0; k < 40; k++)
      chk("dot pattern", 16'(pat[k]), 16'(dots[k]));
    prev = {mirror, com_idx};
    for (int p = 0; p < 8; p++)
    begin
      n = 0;
      while (com_idx === prev[1:0] && n < 2000)
      begin
        @(posedge sys_clk);
        #2 n++;
      end
      chk("common walk", 16'({prev[2] ^ (prev[1:0] == 2'h3), prev[1:0] + 2'h1}), 16'({mirror, com_idx}));
      prev = {mirror, com_idx};
    end
    wr(6'h27, ~pat[39]);
    op(6, 4'h0);
    repeat (2100) @(posedge sys_clk);
    #2;
    chk("live update", 16'(4'(~pat[39])), 16'(dots[39]));
    op(5, 4'h0);
    op(6, 4'h0);
    chk("display off", 16'h0, 16'(display_enabled));
    chk("pins off", 16'h0, 16'(|{segs, coms}));
    $display("t_scan done");
  endtask : t_scan
  task automatic t_rate;
    int c;
    for (int r = 0; r < 4; r++)
    begin
      // ratio moves only while off, so no folded phase reaches the pins
      op(5, 4'h0);
      op(6, 4'h0);
      ratio_sel = 2'(r);
      repeat (8) @(posedge sys_clk);
      #2;
      op(4, 4'h0);
      op(6, 4'h0);
      span(1'b0, c);
      chk("alternating period", 16'(256 << r), 16'(c));
      span(1'b1, c);
      chk("frame period", 16'(1024 << r), 16'(c));
    end
    $display("t_rate done");
  endtask : t_rate
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // main sequence, ending with a reset while the panel is driven
  initial
  begin
    t_reset;
    t_mem;
    t_scan;
    t_rate;
    t_reset;
    stop_test;
  end
  // watchdog sized above the roughly 52000 cycles the tests need
  initial
  begin
    #(25 * 100000);
    error_cnt++;
    stop_test;
  end
endmodule : test_segment_lcd_driver
bind sld_driver sld_props #(.SEGMENTS(SEGMENTS), .COMMONS(COMMONS)) props (.sys_clk(sys_clk), .rst(rst),
  .cmd(cmd), .fetch_data(fetch_data), .fetch_valid(fetch_valid), .display_enabled(display_enabled),
  .segment_outputs(segment_outputs), .common_outputs(common_outputs));
